// ---- hdl/reg_access_bank.sv ----
// Register bank showing the generic peripheral register access conventions
`timescale 1ns/1ps
module reg_access_bank
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       soft_reset,
   input  wire regconv_pkg::bus_req_type   bus_req,
   input  wire logic                       set_same_cycle,
   input  wire logic [7:0]                 set_same_data,
   input  wire logic [7:0]                 hw_status,
   output logic [7:0]                      rdata,
   output logic [7:0]                      ctrl_out,
   output logic [7:0]                      flags_out,
   output logic [7:0]                      debug_out,
   output logic [7:0]                      cmd_out,
   output logic                            cmd_strobe
);

   regconv_pkg::bank_state_type state_reg;   // Registered state
   regconv_pkg::bank_state_type state_next;  // Next state
   logic [7:0]                  status_view; // Status as presented to software
   logic [7:0]                  set_bits;    // Bits set this cycle
   logic [7:0]                  clr_bits;    // Bits cleared this cycle

   // Replace a reserved mode encoding in a status byte
   function automatic logic [7:0] sanitize(input logic [7:0] v);
      logic [7:0] r;
      r = v;
      if (v[regconv_pkg::MODE_LSB +: 2] == regconv_pkg::MODE_RESERVED)
      begin
         r[regconv_pkg::MODE_LSB +: 2] = regconv_pkg::MODE_SAFE;
      end
      return r;
   endfunction

   // Write hit on a given index
   function automatic logic wr_hit(input regconv_pkg::bus_req_type q, input logic [2:0] a);
      return q.wr && (q.addr == a);
   endfunction

   // Status view never shows a reserved field value
   always_comb
   begin
      status_view = sanitize(hw_status);
   end

   // Next-state logic for all registers
   always_comb
   begin
      state_next = state_reg;
      state_next.cmd_stb = 1'b0;
      set_bits = regconv_pkg::ZERO_BYTE;
      clr_bits = regconv_pkg::ZERO_BYTE;
      // Read/write control keeps only implemented bits
      if (wr_hit(bus_req, regconv_pkg::ADDR_CTRL))
      begin
         state_next.ctrl = bus_req.wdata & regconv_pkg::CTRL_MASK;
      end
      // Write-only command captures data and pulses
      if (wr_hit(bus_req, regconv_pkg::ADDR_CMD))
      begin
         state_next.cmd = bus_req.wdata;
         state_next.cmd_stb = 1'b1;
      end
      // Debug control is plain read/write
      if (wr_hit(bus_req, regconv_pkg::ADDR_DEBUG))
      begin
         state_next.debug = bus_req.wdata;
      end
      // Alias writes only act on bits written as one
      if (wr_hit(bus_req, regconv_pkg::ADDR_FLAGS_SET))
      begin
         set_bits = bus_req.wdata;
      end
      if (set_same_cycle)
      begin
         set_bits = set_bits | set_same_data;  // Second port for a simultaneous set
      end
      if (wr_hit(bus_req, regconv_pkg::ADDR_FLAGS_CLR))
      begin
         clr_bits = bus_req.wdata;
      end
      // Clear applied after set so it takes precedence
      state_next.flags = (state_reg.flags | set_bits) & ~clr_bits;
      // Writes to status fall through untouched
      // Read mux, unmapped indices read zero
      state_next.rdata = regconv_pkg::ZERO_BYTE;
      if (bus_req.rd)
      begin
         if (bus_req.addr == regconv_pkg::ADDR_CTRL)
         begin
            state_next.rdata = state_reg.ctrl & regconv_pkg::CTRL_MASK;
         end
         else if (bus_req.addr == regconv_pkg::ADDR_STATUS)
         begin
            state_next.rdata = status_view;
         end
         else if (bus_req.addr == regconv_pkg::ADDR_CMD)
         begin
            state_next.rdata = regconv_pkg::ZERO_BYTE;
         end
         else if (bus_req.addr == regconv_pkg::ADDR_FLAGS_SET || bus_req.addr == regconv_pkg::ADDR_FLAGS_CLR)
         begin
            state_next.rdata = state_reg.flags;
         end
         else if (bus_req.addr == regconv_pkg::ADDR_DEBUG)
         begin
            state_next.rdata = state_reg.debug;
         end
         else
         begin
            state_next.rdata = regconv_pkg::ZERO_BYTE;
         end
      end
      // Soft reset restores all but debug control and registered read data
      if (soft_reset)
      begin
         state_next.ctrl    = regconv_pkg::CTRL_RESET;
         state_next.cmd     = regconv_pkg::CMD_RESET;
         state_next.cmd_stb = 1'b0;
         state_next.flags   = regconv_pkg::FLAGS_RESET;
      end
   end

   // State register, power reset loads every reset value
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg.ctrl    <= regconv_pkg::CTRL_RESET;
         state_reg.cmd     <= regconv_pkg::CMD_RESET;
         state_reg.cmd_stb <= 1'b0;
         state_reg.flags   <= regconv_pkg::FLAGS_RESET;
         state_reg.debug   <= regconv_pkg::DEBUG_RESET;
         state_reg.rdata   <= regconv_pkg::ZERO_BYTE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign rdata      = state_reg.rdata;
   assign ctrl_out   = state_reg.ctrl;
   assign flags_out  = state_reg.flags;
   assign debug_out  = state_reg.debug;
   assign cmd_out    = state_reg.cmd;
   assign cmd_strobe = state_reg.cmd_stb;

   // Command write taken on the bus, not overridden by soft reset
   sequence s_cmd_taken;
      wr_hit(bus_req, regconv_pkg::ADDR_CMD) && !soft_reset;
   endsequence

   // Strobe high with the written byte, then low unless another command follows
   sequence s_cmd_pulse;
      cmd_strobe && cmd_out == $past(bus_req.wdata)
      ##1 (!cmd_strobe || wr_hit($past(bus_req), regconv_pkg::ADDR_CMD));
   endsequence

   // Control write is stored with reserved bits dropped
   a_ctrl_write_stored: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit(bus_req, regconv_pkg::ADDR_CTRL) && !soft_reset
      |=> ctrl_out == ($past(bus_req.wdata) & regconv_pkg::CTRL_MASK))
      else $error("control write not stored");

   // Reserved control bits never hold a one
   a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
      (ctrl_out & ~regconv_pkg::CTRL_MASK) == regconv_pkg::ZERO_BYTE)
      else $error("reserved control bits not zero");

   // Status read passes a legal hardware value through unchanged
   a_status_read: assert property (@(posedge clk) disable iff (!resetn)
      bus_req.rd && bus_req.addr == regconv_pkg::ADDR_STATUS
      && hw_status[regconv_pkg::MODE_LSB +: 2] != regconv_pkg::MODE_RESERVED
      |=> rdata == $past(hw_status))
      else $error("status read wrong");

   // No status read ever shows the reserved mode encoding
   a_status_no_reserved: assert property (@(posedge clk) disable iff (!resetn)
      bus_req.rd && bus_req.addr == regconv_pkg::ADDR_STATUS
      |=> rdata[regconv_pkg::MODE_LSB +: 2] != regconv_pkg::MODE_RESERVED)
      else $error("reserved encoding read");

   // A reserved hardware mode is shown as the safe encoding
   a_status_safe: assert property (@(posedge clk) disable iff (!resetn)
      bus_req.rd && bus_req.addr == regconv_pkg::ADDR_STATUS
      && hw_status[regconv_pkg::MODE_LSB +: 2] == regconv_pkg::MODE_RESERVED
      |=> rdata[regconv_pkg::MODE_LSB +: 2] == regconv_pkg::MODE_SAFE)
      else $error("reserved mode not replaced");

   // Command write gives a one-cycle strobe with the written byte
   a_cmd_pulse: assert property (@(posedge clk) disable iff (!resetn)
      s_cmd_taken |=> s_cmd_pulse)
      else $error("command pulse wrong");

   // Write-only command reads back as zero
   a_cmd_read_zero: assert property (@(posedge clk) disable iff (!resetn)
      bus_req.rd && bus_req.addr == regconv_pkg::ADDR_CMD |=> rdata == regconv_pkg::ZERO_BYTE)
      else $error("command read not zero");

   // Soft reset restores the peripheral registers
   a_soft_reset: assert property (@(posedge clk) disable iff (!resetn)
      soft_reset
      |=> ctrl_out == regconv_pkg::CTRL_RESET && flags_out == regconv_pkg::FLAGS_RESET
      && cmd_out == regconv_pkg::CMD_RESET && !cmd_strobe)
      else $error("soft reset values wrong");

   // Debug control keeps its contents across a soft reset
   a_debug_kept: assert property (@(posedge clk) disable iff (!resetn)
      soft_reset && !wr_hit(bus_req, regconv_pkg::ADDR_DEBUG) |=> debug_out == $past(debug_out))
      else $error("debug lost on soft reset");

   // Ones on the clear alias always clear, even against a set
   a_clear_alias: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit(bus_req, regconv_pkg::ADDR_FLAGS_CLR)
      |=> (flags_out & $past(bus_req.wdata)) == regconv_pkg::ZERO_BYTE)
      else $error("clear alias failed");

   // Zeros on the clear alias leave the other flags alone
   a_clear_keeps: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit(bus_req, regconv_pkg::ADDR_FLAGS_CLR) && !set_same_cycle && !soft_reset
      |=> flags_out == ($past(flags_out) & ~$past(bus_req.wdata)))
      else $error("clear alias touched other bits");

   // Set alias ORs its ones into the flags and nothing else
   a_set_alias: assert property (@(posedge clk) disable iff (!resetn)
      wr_hit(bus_req, regconv_pkg::ADDR_FLAGS_SET) && !soft_reset
      |=> flags_out == ($past(flags_out) | $past(bus_req.wdata)
                        | ($past(set_same_data) & {regconv_pkg::DATA_W{$past(set_same_cycle)}})))
      else $error("set alias failed");

   // Both aliases read back the shared flag storage
   a_alias_same_read: assert property (@(posedge clk) disable iff (!resetn)
      bus_req.rd
      && (bus_req.addr == regconv_pkg::ADDR_FLAGS_SET || bus_req.addr == regconv_pkg::ADDR_FLAGS_CLR)
      |=> rdata == $past(flags_out))
      else $error("alias read differs");

endmodule // reg_access_bank

// ---- hdl/regconv_pkg.sv ----
// Package: constants and types for the generic register access bank
package regconv_pkg;
   // Byte-wide peripheral registers
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned ADDR_W          = 3;
   // Register indices on the internal peripheral bus
   localparam logic [2:0]  ADDR_CTRL       = 3'h0;  // Read/write control with reserved bits
   localparam logic [2:0]  ADDR_STATUS     = 3'h1;  // Read-only status
   localparam logic [2:0]  ADDR_CMD        = 3'h2;  // Write-only command
   localparam logic [2:0]  ADDR_FLAGS_SET  = 3'h3;  // Set alias of flag storage
   localparam logic [2:0]  ADDR_FLAGS_CLR  = 3'h4;  // Clear alias of flag storage
   localparam logic [2:0]  ADDR_DEBUG      = 3'h5;  // Debug control, survives soft reset
   // Implemented bits of the control register; the rest are reserved
   localparam logic [7:0]  CTRL_MASK       = 8'h1f;
   // Field position of the two-bit mode field inside status
   localparam int unsigned MODE_LSB        = 3;
   // Reserved encoding of the mode field and its safe replacement
   localparam logic [1:0]  MODE_RESERVED   = 2'h3;
   localparam logic [1:0]  MODE_SAFE       = 2'h0;
   // Reset values
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  CMD_RESET       = 8'h00;
   localparam logic [7:0]  FLAGS_RESET     = 8'h00;
   localparam logic [7:0]  DEBUG_RESET     = 8'h00;
   localparam logic [7:0]  ZERO_BYTE       = 8'h00;
   // Write strobe and read request bundle from the peripheral bus
   typedef struct packed {
      logic             wr;     // Write strobe
      logic             rd;     // Read strobe
      logic [2:0]       addr;   // Register index
      logic [7:0]       wdata;  // Write data
   } bus_req_type;
   // Whole state of the register bank
   typedef struct packed {
      logic [7:0]       ctrl;   // Read/write storage
      logic [7:0]       cmd;    // Last command, write-only
      logic             cmd_stb;// One-cycle command pulse
      logic [7:0]       flags;  // Shared set/clear storage
      logic [7:0]       debug;  // Debug control
      logic [7:0]       rdata;  // Registered read data
   } bank_state_type;
endpackage

// ---- testbench/tb_top.sv ----
// Self-checking testbench for the register access bank
`timescale 1ns/1ps
module tb_top;
   // Row: status input, write index and data, read index, expected read data
   typedef struct packed {
      logic [7:0] hw;
      logic [2:0] addr;
      logic [7:0] wdata;
      logic [2:0] raddr;
      logic [7:0] exp;
   } row_type;
   logic                      clk;            // Peripheral clock
   logic                      resetn;         // Power reset, active low
   logic                      soft_reset;     // Peripheral soft reset
   regconv_pkg::bus_req_type  bus_req;        // Bus request bundle
   logic                      set_same_cycle; // Extra set source
   logic [7:0]                set_same_data;  // Extra set data
   logic [7:0]                hw_status;      // Hardware status value
   logic [7:0]                rdata;          // Read data
   logic [7:0]                ctrl_out;       // Stored control
   logic [7:0]                flags_out;      // Shared flag storage
   logic [7:0]                debug_out;      // Debug control
   logic [7:0]                cmd_out;        // Last command
   logic                      cmd_strobe;     // Command pulse
   int                        n_mismatch;     // Failed comparisons
   int                        n_tests;        // All comparisons
   row_type                   rows [10];      // Ordinary cases
   reg_access_bank u_dut (.clk(clk), .resetn(resetn), .soft_reset(soft_reset), .bus_req(bus_req),
      .set_same_cycle(set_same_cycle), .set_same_data(set_same_data), .hw_status(hw_status),
      .rdata(rdata), .ctrl_out(ctrl_out), .flags_out(flags_out), .debug_out(debug_out),
      .cmd_out(cmd_out), .cmd_strobe(cmd_strobe));
   // Clock at 50 ns period
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Byte comparison with four-state equality
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One bus cycle, request held across exactly one sampling edge
   task automatic xfer(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d,
                       input logic ss, input logic [7:0] ssd);
      @(posedge clk);
      #1;
      bus_req = '{wr: w, rd: r, addr: a, wdata: d};
      set_same_cycle = ss;
      set_same_data = ssd;
      @(posedge clk);
      #1;
      bus_req = '0;
      set_same_cycle = 1'b0;
      set_same_data = 8'h00;
   endtask
   // Soft reset pulse with a write on the bus in the same cycle
   task automatic soft_xfer(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      soft_reset = 1'b1;
      bus_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      #1;
      soft_reset = 1'b0;
      bus_req = '0;
   endtask
   // Final counts and verdict
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Cut a hang short
   initial
   begin
      #2000000;
      n_mismatch++;
      stop_test();
   end
   // Main sequence
   initial
   begin
      n_mismatch = 0;
      n_tests = 0;
      resetn = 1'b0;
      soft_reset = 1'b0;
      bus_req = '0;
      set_same_cycle = 1'b0;
      set_same_data = 8'h00;
      hw_status = 8'h00;
      rows = '{'{8'h00, regconv_pkg::ADDR_CTRL, 8'h07, regconv_pkg::ADDR_CTRL, 8'h07},
               '{8'h00, regconv_pkg::ADDR_CTRL, 8'hef, regconv_pkg::ADDR_CTRL, 8'h0f},       // ones on purpose
               '{8'h05, regconv_pkg::ADDR_STATUS, 8'haa, regconv_pkg::ADDR_STATUS, 8'h05},
               '{8'h1b, regconv_pkg::ADDR_STATUS, 8'h00, regconv_pkg::ADDR_STATUS, 8'h03},
               '{8'h00, regconv_pkg::ADDR_CMD, 8'h5a, regconv_pkg::ADDR_CMD, 8'h00},
               '{8'h00, regconv_pkg::ADDR_FLAGS_SET, 8'h0f, regconv_pkg::ADDR_FLAGS_CLR, 8'h0f},
               '{8'h00, regconv_pkg::ADDR_FLAGS_CLR, 8'h03, regconv_pkg::ADDR_FLAGS_SET, 8'h0c},
               '{8'h00, regconv_pkg::ADDR_FLAGS_SET, 8'h00, regconv_pkg::ADDR_FLAGS_CLR, 8'h0c},
               '{8'h00, 3'h6, 8'hff, 3'h6, 8'h00},
               '{8'h00, regconv_pkg::ADDR_DEBUG, 8'h33, regconv_pkg::ADDR_DEBUG, 8'h33}};
      repeat (8) @(posedge clk);
      #1;
      resetn = 1'b1;
      chk(ctrl_out, regconv_pkg::CTRL_RESET, "power ctrl");
      chk(flags_out, regconv_pkg::FLAGS_RESET, "power flags");
      chk(debug_out, regconv_pkg::DEBUG_RESET, "power debug");
      chk(cmd_out, regconv_pkg::CMD_RESET, "power cmd");
      chk(rdata, 8'h00, "power rdata");
      chk({7'h0, cmd_strobe}, 8'h00, "power strobe");
      $display("Test reset done");
      // Write, then read back through the paired or same index
      foreach (rows[i])
      begin
         hw_status = rows[i].hw;
         // Some writes (5a, ff) carry the reserved mode value in bits 4:3; no fuse location exists to touch
         xfer(1'b1, 1'b0, rows[i].addr, rows[i].wdata, 1'b0, 8'h00);
         xfer(1'b0, 1'b1, rows[i].raddr, 8'h00, 1'b0, 8'h00);
         chk(rdata, rows[i].exp, "row read");
      end
      $display("Test rows done");
      // Command pulse lasts one cycle
      xfer(1'b1, 1'b0, regconv_pkg::ADDR_CMD, 8'ha5, 1'b0, 8'h00);
      chk(cmd_out, 8'ha5, "command value");
      chk({7'h0, cmd_strobe}, 8'h01, "strobe high");
      @(posedge clk);
      #1;
      chk({7'h0, cmd_strobe}, 8'h00, "strobe low");
      // Clear and set in the same cycle
      xfer(1'b1, 1'b0, regconv_pkg::ADDR_FLAGS_CLR, 8'h04, 1'b1, 8'h05);
      chk(flags_out, 8'h09, "clear beats set");
      $display("Test alias done");
      // Soft reset keeps debug control only
      @(posedge clk);
      #1;
      soft_reset = 1'b1;
      @(posedge clk);
      #1;
      soft_reset = 1'b0;
      chk(ctrl_out, 8'h00, "soft ctrl");
      chk(flags_out, 8'h00, "soft flags");
      chk(cmd_out, 8'h00, "soft cmd");
      chk(debug_out, 8'h33, "soft debug");
      chk({7'h0, cmd_strobe}, 8'h00, "soft strobe");
      // Read and write of control in one cycle, the read sees the old value
      xfer(1'b1, 1'b1, regconv_pkg::ADDR_CTRL, 8'h06, 1'b0, 8'h00);
      chk(rdata, 8'h00, "read before write");
      chk(ctrl_out, 8'h06, "write with read");
      // Soft reset beats a control write, a debug write still lands
      soft_xfer(regconv_pkg::ADDR_CTRL, 8'h05);
      chk(ctrl_out, 8'h00, "soft beats write");
      soft_xfer(regconv_pkg::ADDR_DEBUG, 8'h44);
      chk(debug_out, 8'h44, "debug write in soft");
      // Power reset clears debug control too
      resetn = 1'b0;
      #1;
      chk(debug_out, 8'h00, "power debug");
      @(posedge clk);
      #1;
      resetn = 1'b1;
      // First requests right after a mid-run release
      xfer(1'b0, 1'b1, regconv_pkg::ADDR_DEBUG, 8'h00, 1'b0, 8'h00);
      chk(rdata, 8'h00, "debug after power");
      chk(ctrl_out, 8'h00, "ctrl after power");
      $display("Test resets done");
      stop_test();
   end
endmodule // tb_top
